// file: core/audio_capture_dma.sv
// Notes on behaviour
// - Samples are eight or sixteen bits wide and packed into 32-bit words.
// - The initiator follows its own instruction list fetched from host memory.
// - Audio flow and fetching never wait on any video activity.
// - Samples stream continuously with no sync gaps inserted.
// - Packed write instructions move a count of words to a target address.
// - One 35 by 36 FIFO with a 6-bit word counter buffers data.
// - Retries on this initiator are handled here, independent of video.
// - Same initiator interface as video, with interrupt support.
// - All control state lives in the bus clock domain; bus addresses and data are 32-bit wide.
// - The register target never signals disconnect or retry.
// - Target provides interrupts and bus parity error checking.
`timescale 1ns/1ps
module audio_capture_dma (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic [31:0] list_addr_i,
  input wire logic wide_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  input wire logic irq_en_i,
  input wire logic status_clr_i,
  input wire logic tgt_valid_i,
  input wire logic [31:0] tgt_data_i,
  input wire logic tgt_par_i,
  input wire logic mem_gnt_i,
  input wire logic mem_retry_i,
  input wire logic mem_rvalid_i,
  input wire logic [31:0] mem_rdata_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  output logic [5:0] fifo_words_o,
  output logic overrun_o,
  output logic list_irq_o,
  output logic list_err_o,
  output logic parity_err_o,
  output logic irq_o,
  output logic halted_o,
  output logic tgt_stop_o
);
  localparam int AW = audio_dma_pkg::ADDR_W;
  localparam int DW = audio_dma_pkg::DATA_W;
  localparam int CW = audio_dma_pkg::CNT_W;

  audio_dma_pkg::seq_state_e state_q;
  logic [AW-1:0] pc_q;
  logic [AW-1:0] dest_q;
  logic [CW-1:0] left_q;
  logic [3:0] op_q;
  logic rd_wait_q;
  logic [DW-1:0] pack_q;
  logic [1:0] lane_q;
  logic push;
  logic [audio_dma_pkg::FIFO_W-1:0] push_data;
  logic [audio_dma_pkg::FIFO_W-1:0] head;
  logic fifo_full;
  logic fifo_empty;
  logic [5:0] fifo_cnt;
  logic accepted;
  logic issue_read;
  logic issue_write;
  logic [DW-1:0] word_next;
  logic word_done;
  logic set_overrun;
  logic set_list_irq;
  logic set_list_err;
  logic set_parity;
  logic [3:0] fetched_op;

  function automatic logic [AW-1:0] next_word(input logic [AW-1:0] a);
    next_word = a + audio_dma_pkg::WORD_STEP;
  endfunction

  // Bus parity covers the data word and the parity bit, even in total.
  function automatic logic parity_bad(input logic [DW-1:0] d,
                                      input logic p);
    parity_bad = ^{d, p};
  endfunction

  // Sample packer, low lanes first; it never stalls the sample source.
  always_comb begin
    word_next = pack_q;
    if (wide_i) begin
      if (lane_q == audio_dma_pkg::LANE_FIRST) begin
        word_next[15:0] = sample_i;
      end else begin
        word_next[31:16] = sample_i;
      end
    end else begin
      case (lane_q)
        2'h0: word_next[7:0] = sample_i[7:0];
        2'h1: word_next[15:8] = sample_i[7:0];
        2'h2: word_next[23:16] = sample_i[7:0];
        default: word_next[31:24] = sample_i[7:0];
      endcase
    end
  end

  assign word_done = sample_valid_i && run_i &&
    (wide_i ? (lane_q == audio_dma_pkg::LANE_LAST16)
            : (lane_q == audio_dma_pkg::LANE_LAST8));
  assign push = word_done && !fifo_full;
  assign push_data = {audio_dma_pkg::BE_ALL, word_next};
  // A full FIFO refuses the word even if a pop frees a slot in that cycle;
  // the count logic stays simple at the price of that one word.
  assign set_overrun = word_done && fifo_full;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pack_q <= audio_dma_pkg::DATA_RST;
      lane_q <= audio_dma_pkg::LANE_FIRST;
    end else if (!run_i) begin
      // A partial word is dropped when capture stops.
      lane_q <= audio_dma_pkg::LANE_FIRST;
    end else if (sample_valid_i) begin
      pack_q <= word_next;
      lane_q <= word_done ? audio_dma_pkg::LANE_FIRST : lane_q + 2'h1;
    end
  end

  audio_word_fifo #(
    .WIDTH(audio_dma_pkg::FIFO_W),
    .DEPTH(audio_dma_pkg::FIFO_DEPTH),
    .CW(audio_dma_pkg::FIFO_CNT_W)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .push_i(push),
    .data_i(push_data),
    .pop_i(issue_write),
    .data_o(head),
    .full_o(fifo_full),
    .empty_o(fifo_empty),
    .count_o(fifo_cnt)
  );

  // A retried request simply stays up; no video state is consulted.
  assign accepted = mem_req_o && mem_gnt_i && !mem_retry_i;
  // A fetch waits until the previous read data has gone by, so only one
  // read is ever outstanding and the returning data needs no tag.
  assign issue_read = ((state_q == audio_dma_pkg::ST_FETCH) ||
                       (state_q == audio_dma_pkg::ST_ARG)) &&
                      run_i && !mem_req_o && !rd_wait_q &&
                      !mem_rvalid_i;
  // A write goes out only with a word already buffered, so a slow sample
  // source leaves the bus idle instead of writing stale data.
  assign issue_write = (state_q == audio_dma_pkg::ST_WRITE) && run_i &&
                       !mem_req_o && !fifo_empty &&
                       (left_q != audio_dma_pkg::CNT_ZERO);
  assign fetched_op = mem_rdata_i[audio_dma_pkg::OP_MSB:
                                  audio_dma_pkg::OP_LSB];
  assign set_list_irq = mem_rvalid_i && rd_wait_q &&
                        (state_q == audio_dma_pkg::ST_FETCH) &&
                        (fetched_op == audio_dma_pkg::OP_STOP ||
                         mem_rdata_i[audio_dma_pkg::IRQ_BIT]);
  assign set_list_err = mem_rvalid_i && rd_wait_q &&
                        (state_q == audio_dma_pkg::ST_FETCH) &&
                        (fetched_op != audio_dma_pkg::OP_WRITE) &&
                        (fetched_op != audio_dma_pkg::OP_JUMP) &&
                        (fetched_op != audio_dma_pkg::OP_STOP);
  assign set_parity = tgt_valid_i && parity_bad(tgt_data_i, tgt_par_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= audio_dma_pkg::ADDR_RST;
      mem_wdata_o <= audio_dma_pkg::DATA_RST;
      mem_be_o <= '0;
    end else if (issue_write) begin
      mem_req_o <= 1'b1;
      mem_we_o <= 1'b1;
      mem_addr_o <= dest_q;
      mem_wdata_o <= head[DW-1:0];
      mem_be_o <= head[audio_dma_pkg::FIFO_W-1:DW];
    end else if (issue_read) begin
      mem_req_o <= 1'b1;
      mem_we_o <= 1'b0;
      mem_addr_o <= pc_q;
      mem_be_o <= audio_dma_pkg::BE_ALL;
    end else if (accepted) begin
      mem_req_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_wait_q <= 1'b0;
    end else if (accepted && !mem_we_o) begin
      rd_wait_q <= 1'b1;
    end else if (mem_rvalid_i) begin
      rd_wait_q <= 1'b0;
    end
  end

  // Instruction sequencer.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= audio_dma_pkg::ST_IDLE;
      pc_q <= audio_dma_pkg::ADDR_RST;
      dest_q <= audio_dma_pkg::ADDR_RST;
      left_q <= audio_dma_pkg::CNT_ZERO;
      op_q <= '0;
    end else if (!run_i) begin
      // Stopping waits for any access in flight, so late read data is
      // never taken as the first word of a new list.
      if (!mem_req_o && !rd_wait_q) begin
        state_q <= audio_dma_pkg::ST_IDLE;
      end
    end else begin
      case (state_q)
        audio_dma_pkg::ST_IDLE: begin
          pc_q <= list_addr_i;
          state_q <= audio_dma_pkg::ST_FETCH;
        end
        audio_dma_pkg::ST_FETCH: begin
          if (mem_rvalid_i && rd_wait_q) begin
            pc_q <= next_word(pc_q);
            op_q <= fetched_op;
            left_q <= mem_rdata_i[audio_dma_pkg::LEN_MSB:
                                  audio_dma_pkg::LEN_LSB];
            if (fetched_op == audio_dma_pkg::OP_WRITE ||
                fetched_op == audio_dma_pkg::OP_JUMP) begin
              state_q <= audio_dma_pkg::ST_ARG;
            end else begin
              state_q <= audio_dma_pkg::ST_HALT;
            end
          end
        end
        audio_dma_pkg::ST_ARG: begin
          if (mem_rvalid_i && rd_wait_q) begin
            if (op_q == audio_dma_pkg::OP_JUMP) begin
              pc_q <= mem_rdata_i;
              state_q <= audio_dma_pkg::ST_FETCH;
            end else begin
              pc_q <= next_word(pc_q);
              dest_q <= mem_rdata_i;
              state_q <= (left_q == audio_dma_pkg::CNT_ZERO) ?
                         audio_dma_pkg::ST_FETCH : audio_dma_pkg::ST_WRITE;
            end
          end
        end
        audio_dma_pkg::ST_WRITE: begin
          if (accepted && mem_we_o) begin
            dest_q <= next_word(dest_q);
            left_q <= left_q - audio_dma_pkg::CNT_ONE;
            if (left_q == audio_dma_pkg::CNT_ONE) begin
              state_q <= audio_dma_pkg::ST_FETCH;
            end
          end
        end
        // The halt is left only through run_i going low, so software sees
        // the stop and restarts the list on purpose.
        default: begin
          state_q <= audio_dma_pkg::ST_HALT;
        end
      endcase
    end
  end

  // Sticky status: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overrun_o <= 1'b0;
      list_irq_o <= 1'b0;
      list_err_o <= 1'b0;
      parity_err_o <= 1'b0;
    end else begin
      overrun_o <= set_overrun || (overrun_o && !status_clr_i);
      list_irq_o <= set_list_irq || (list_irq_o && !status_clr_i);
      list_err_o <= set_list_err || (list_err_o && !status_clr_i);
      parity_err_o <= set_parity || (parity_err_o && !status_clr_i);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_en_i && (set_overrun || set_list_irq || set_list_err ||
               set_parity ||
               ((overrun_o || list_irq_o || list_err_o || parity_err_o) &&
                !status_clr_i));
    end
  end

  // Everything is local to the bus clock, so the target can always
  // finish an access and has no reason to stop it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgt_stop_o <= 1'b0;
      halted_o <= 1'b0;
      fifo_words_o <= '0;
    end else begin
      tgt_stop_o <= 1'b0;
      halted_o <= (state_q == audio_dma_pkg::ST_HALT);
      fifo_words_o <= fifo_cnt;
    end
  end
endmodule

// file: core/audio_dma_pkg.sv
package audio_dma_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int FIFO_W = 36;
  localparam int FIFO_DEPTH = 35;
  localparam int FIFO_CNT_W = 6;
  localparam int SAMPLE_W = 16;
  localparam int CNT_W = 12;

  // Instruction word layout.
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 28;
  localparam int IRQ_BIT = 24;
  localparam int LEN_MSB = 11;
  localparam int LEN_LSB = 0;

  // Opcodes.
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_JUMP = 4'h7;
  localparam logic [3:0] OP_STOP = 4'hF;

  // Packing lanes and byte enables.
  localparam logic [1:0] LANE_FIRST = 2'h0;
  localparam logic [1:0] LANE_LAST8 = 2'h3;
  localparam logic [1:0] LANE_LAST16 = 2'h1;
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;

  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_ARG   = 3'h3,
    ST_WRITE = 3'h2,
    ST_HALT  = 3'h6
  } seq_state_e;
endpackage

// file: core/audio_word_fifo.sv
`timescale 1ns/1ps
module audio_word_fifo #(
  parameter int WIDTH = audio_dma_pkg::FIFO_W,
  parameter int DEPTH = audio_dma_pkg::FIFO_DEPTH,
  parameter int CW = audio_dma_pkg::FIFO_CNT_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] data_o,
  output logic full_o,
  output logic empty_o,
  output logic [CW-1:0] count_o
);
  localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0] wr_q;
  logic [CW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  // Pointers wrap at the depth, which need not be a power of two.
  function automatic logic [CW-1:0] wrap_inc(input logic [CW-1:0] p);
    wrap_inc = (p == LAST) ? ZERO : p + ONE;
  endfunction

  assign do_push = push_i && (cnt_q != FULLC);
  assign do_pop = pop_i && (cnt_q != ZERO);
  assign data_o = mem_q[rd_q];
  assign full_o = (cnt_q == FULLC);
  assign empty_o = (cnt_q == ZERO);
  assign count_o = cnt_q;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wr_q] <= data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= ZERO;
      rd_q <= ZERO;
    end else begin
      if (do_push) begin
        wr_q <= wrap_inc(wr_q);
      end
      if (do_pop) begin
        rd_q <= wrap_inc(rd_q);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= ZERO;
    end else if (do_push && !do_pop) begin
      cnt_q <= cnt_q + ONE;
    end else if (do_pop && !do_push) begin
      cnt_q <= cnt_q - ONE;
    end
  end
endmodule

// file: tb/audio_capture_dma_asserts.sv
`timescale 1ns/1ps
module audio_capture_dma_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tgt_valid_i,
  input wire logic [31:0] tgt_data_i,
  input wire logic tgt_par_i,
  input wire logic mem_gnt_i,
  input wire logic mem_retry_i,
  input wire logic status_clr_i,
  input wire logic irq_en_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic [3:0] mem_be_o,
  input wire logic [5:0] fifo_words_o,
  input wire logic overrun_o,
  input wire logic parity_err_o,
  input wire logic irq_o,
  input wire logic tgt_stop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence take_s;
    mem_req_o && mem_gnt_i && !mem_retry_i;
  endsequence
  sequence wait_s;
    mem_req_o && !(mem_gnt_i && !mem_retry_i);
  endsequence
  no_stop_a: assert property (!tgt_stop_o)
    else $error("target stop raised");
  req_hold_a: assert property (wait_s |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_wdata_o) && $stable(mem_we_o))
    else $error("request changed before acceptance");
  one_read_a: assert property (take_s ##0 !mem_we_o |=> !mem_req_o)
    else $error("second read while one outstanding");
  full_be_a: assert property (mem_req_o && mem_we_o |-> mem_be_o == 4'hF)
    else $error("write not a whole word");
  fifo_depth_a: assert property (fifo_words_o <= 6'h23)
    else $error("word count above depth");
  parity_set_a: assert property (tgt_valid_i && ^{tgt_data_i, tgt_par_i}
    |=> parity_err_o)
    else $error("parity error not flagged");
  overrun_hold_a: assert property (overrun_o && !status_clr_i |=> overrun_o)
    else $error("overrun flag lost");
  irq_mask_a: assert property (!irq_en_i |=> !irq_o)
    else $error("masked interrupt raised");
  irq_raise_a: assert property (irq_en_i && overrun_o && !status_clr_i
    |=> irq_o)
    else $error("pending interrupt not raised");
endmodule
bind audio_capture_dma audio_capture_dma_asserts u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .tgt_valid_i(tgt_valid_i),
  .tgt_data_i(tgt_data_i), .tgt_par_i(tgt_par_i), .mem_gnt_i(mem_gnt_i),
  .mem_retry_i(mem_retry_i), .status_clr_i(status_clr_i),
  .irq_en_i(irq_en_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_be_o(mem_be_o), .fifo_words_o(fifo_words_o),
  .overrun_o(overrun_o), .parity_err_o(parity_err_o), .irq_o(irq_o),
  .tgt_stop_o(tgt_stop_o));

// file: tb/audio_capture_dma_channel_tb_top.sv
`timescale 1ns/1ps
module audio_capture_dma_channel_tb_top;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic run_i = 1'h0, wide_i = 1'h0, sample_valid_i = 1'h0, irq_en_i = 1'h0;
  logic status_clr_i = 1'h0, tgt_valid_i = 1'h0, tgt_par_i = 1'h0;
  logic stall = 1'h0, retry_en = 1'h0;
  logic [15:0] sample_i = 16'h0;
  logic [31:0] list_addr_i = 32'h0, tgt_data_i = 32'h0, mem_rdata_i;
  logic mem_gnt_i, mem_retry_i, mem_rvalid_i, mem_req_o, mem_we_o;
  logic [31:0] mem_addr_o, mem_wdata_o, exp_addr;
  logic [3:0] mem_be_o;
  logic [5:0] fifo_words_o;
  logic overrun_o, list_irq_o, list_err_o, parity_err_o, irq_o, halted_o;
  logic tgt_stop_o;
  int n_errors = 0, checks_done = 0;
  logic [31:0] exp_q [$];
  localparam logic [31:0] BASE = 32'h1000_0000;
  always #25 clk_i = ~clk_i;
  audio_capture_dma dut (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run_i),
    .list_addr_i(list_addr_i), .wide_i(wide_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .irq_en_i(irq_en_i), .status_clr_i(status_clr_i),
    .tgt_valid_i(tgt_valid_i), .tgt_data_i(tgt_data_i),
    .tgt_par_i(tgt_par_i), .mem_gnt_i(mem_gnt_i),
    .mem_retry_i(mem_retry_i), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_be_o(mem_be_o), .fifo_words_o(fifo_words_o),
    .overrun_o(overrun_o), .list_irq_o(list_irq_o),
    .list_err_o(list_err_o), .parity_err_o(parity_err_o), .irq_o(irq_o),
    .halted_o(halted_o), .tgt_stop_o(tgt_stop_o));
  audio_mem_model mem (.clk_i(clk_i), .resetn_i(resetn_i), .stall_i(stall),
    .retry_en_i(retry_en), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_gnt_o(mem_gnt_i), .mem_retry_o(mem_retry_i),
    .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));
  task automatic check(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (exp !== got) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Even parity over data and parity bit: an odd total is an error.
  function automatic logic parity_error(input logic [31:0] d,
                                        input logic p);
    return ^{d, p};
  endfunction
  // Sixteen-bit samples fill a word in two, eight-bit ones in four.
  function automatic int lanes(input logic w);
    return w ? 2 : 4;
  endfunction
  // Every list writes from BASE, so the expectation restarts while stopped.
  always @(posedge clk_i) begin
    if (!run_i) begin
      exp_addr = BASE;
    end
    if (mem_req_o && mem_we_o && mem_gnt_i && !mem_retry_i) begin
      check("write address", exp_addr, mem_addr_o);
      check("write data", exp_q.size() ? exp_q[0] : 32'h0, mem_wdata_o);
      if (exp_q.size() > 0) void'(exp_q.pop_front());
      exp_addr = exp_addr + 32'h4;
    end
  end
  // Runs one list; st stalls the bus so that one word too many is dropped.
  task automatic play(input logic [3:0] op, input int n, input logic w, st);
    logic [31:0] word;
    mem.list_q[0] = {op, 4'h1, 12'h000, 12'(n)};
    mem.list_q[1] = BASE;
    mem.list_q[2] = {audio_dma_pkg::OP_WRITE, 28'h0};
    mem.list_q[4] = {audio_dma_pkg::OP_JUMP, 28'h0};
    mem.list_q[5] = 32'h20;
    mem.list_q[3] = BASE;
    mem.list_q[8] = {audio_dma_pkg::OP_STOP, 28'h0};
    @(posedge clk_i);
    stall <= st;
    irq_en_i <= st;
    wide_i <= w;
    run_i <= 1'h1;
    for (int k = 0; k < n + int'(st); k++) begin
      word = $urandom;
      for (int l = 0; l < lanes(w); l++) begin
        @(posedge clk_i);
        sample_valid_i <= 1'h1;
        sample_i <= w ? word[16*l +: 16] : {8'($urandom), word[8*l +: 8]};
      end
      exp_q.push_back(word);
    end
    @(posedge clk_i);
    sample_valid_i <= 1'h0;
    if (st) begin
      repeat (3) @(posedge clk_i);
      check("fifo words", 32'd35, fifo_words_o);
      check("overrun", 32'h1, overrun_o);
      void'(exp_q.pop_back());
      stall <= 1'h0;
    end
    for (int c = 0; c < 3000 && halted_o !== 1'h1; c++) @(posedge clk_i);
    check("halted", 32'h1, halted_o);
    check("list irq", 32'h1, list_irq_o);
    check("list err", 32'(op == 4'h3), list_err_o);
    check("irq", 32'(st), irq_o);
    check("left over", 32'h0, exp_q.size());
    run_i <= 1'h0;
    status_clr_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    status_clr_i <= 1'h0;
    @(posedge clk_i);
    check("flags cleared", 32'h0,
          {overrun_o, list_irq_o, list_err_o, irq_o});
    $display("list op %h words %0d wide %0d stall %0d done", op, n, w, st);
  endtask
  initial begin
    logic [31:0] d;
    logic p;
    void'($urandom(32'h19A2));
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'h1;
    retry_en <= 1'h1;
    play(audio_dma_pkg::OP_WRITE, 12, 1'h1, 1'h0);
    play(audio_dma_pkg::OP_WRITE, 13, 1'h0, 1'h0);
    play(audio_dma_pkg::OP_WRITE, 35, 1'h1, 1'h1);
    play(4'h3, 0, 1'h1, 1'h0);
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      p = k[0];
      @(posedge clk_i);
      tgt_valid_i <= 1'h1;
      tgt_data_i <= d;
      tgt_par_i <= p;
      @(posedge clk_i);
      tgt_valid_i <= 1'h0;
      @(posedge clk_i);
      check("parity", 32'(parity_error(d, p)), parity_err_o);
      check("target stop", 32'h0, tgt_stop_o);
      status_clr_i <= 1'h1;
      @(posedge clk_i);
      status_clr_i <= 1'h0;
    end
    $display("parity test done");
    report_and_stop();
  end
  // The tests take a few hundred cycles; this allows 60000 cycles.
  initial begin
    #3000000;
    n_errors++;
    report_and_stop();
  end
endmodule

// file: tb/audio_mem_model.sv
`timescale 1ns/1ps
module audio_mem_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  input wire logic retry_en_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_gnt_o,
  output logic mem_retry_o,
  output logic mem_rvalid_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] list_q [0:15];
  logic take;
  assign take = mem_req_i && mem_gnt_o && !mem_retry_o;
  // Grant and retry are random so that prompt, slow and retried answers mix.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_gnt_o <= 1'h0;
      mem_retry_o <= 1'h0;
      mem_rvalid_o <= 1'h0;
      mem_rdata_o <= 32'h0;
    end else begin
      mem_gnt_o <= !stall_i && ($urandom % 3 != 0);
      mem_retry_o <= retry_en_i && ($urandom % 4 == 0);
      mem_rvalid_o <= take && !mem_we_i;
      // Between answers the data lines toggle, so stale data never matches.
      mem_rdata_o <= (take && !mem_we_i) ? list_q[mem_addr_i[5:2]]
                                         : ~mem_rdata_o;
    end
  end
endmodule
